// ==== dv/serial_baud_rate_generator_tb.sv ====
// Purpose: Self-checking bench for the serial bit rate generator.
// Assumes: AXI4-Lite timing and register map as the package declares them.
// Notes: Tick periods are compared with an integer model; seed is fixed.

`timescale 1ns/1ps

`define CHK(got, exp) begin n_compared++; if ((got) !== (exp)) begin mismatches++; \
	$display("CHECK FAILED t=%0t got %0h exp %0h", $time, (got), (exp)); end end

module serial_baud_rate_generator_tb;

	// ------------------------------------------------------------------
	// Signals
	// ------------------------------------------------------------------
	logic        clk = 1'b0, rst = 1'b1;
	logic [7:0]  aw_addr = 8'h00, ar_addr = 8'h00;
	logic [31:0] w_data = 32'h0, rdata;
	logic [3:0]  w_strb = 4'h0;
	logic        aw_vld = 1'b0, w_vld = 1'b0, b_rdy = 1'b0, ar_vld = 1'b0, r_rdy = 1'b0;
	logic        awrdy, wrdy, bvld, arrdy, rvld, tick, rx_lvl;
	logic        rx_pin = 1'b1, ext_clk = 1'b0;
	logic [1:0]  bresp, rresp, resp;
	logic [31:0] rd;
	int          mismatches = 0, n_compared = 0, cycles = 0, c, k;
	int          modes [6] = '{0, 1, 2, 3, 5, 7};

	serial_baud_rate_generator dut (
		.CORE_CLK_IN(clk), .RST_IN(rst),
		.AXI_AWADDR_IN(aw_addr), .AXI_AWVALID_IN(aw_vld), .AXI_AWREADY_OUT(awrdy),
		.AXI_WDATA_IN(w_data), .AXI_WSTRB_IN(w_strb), .AXI_WVALID_IN(w_vld), .AXI_WREADY_OUT(wrdy),
		.AXI_BRESP_OUT(bresp), .AXI_BVALID_OUT(bvld), .AXI_BREADY_IN(b_rdy),
		.AXI_ARADDR_IN(ar_addr), .AXI_ARVALID_IN(ar_vld), .AXI_ARREADY_OUT(arrdy),
		.AXI_RDATA_OUT(rdata), .AXI_RRESP_OUT(rresp), .AXI_RVALID_OUT(rvld), .AXI_RREADY_IN(r_rdy),
		.RX_PIN_IN(rx_pin), .EXT_CLK_PIN_IN(ext_clk), .BIT_TICK_OUT(tick), .RX_LEVEL_OUT(rx_lvl)
	);

	// ------------------------------------------------------------------
	// Clock and hang guard
	// ------------------------------------------------------------------
	// The 200 MHz clock; the ceiling is well above the longest mode sweep.
	always #2.5 clk = ~clk;
	always @(posedge clk) begin
		cycles++;
		if (cycles == 90000) begin
			mismatches++;
			$display("CHECK FAILED t=%0t timeout", $time);
			wrap_up();
		end
	end

	// ------------------------------------------------------------------
	// Bus tasks
	// ------------------------------------------------------------------
	// Handshakes are judged at the falling edge, where ready is settled, and act at the next rise.
	task automatic axi_write(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
		logic aw_p, w_p, b_p, aw_h, w_h, b_h;
		aw_p = 1'b1; w_p = 1'b1; b_p = 1'b1;
		aw_addr <= a; w_data <= d; w_strb <= s; aw_vld <= 1'b1; w_vld <= 1'b1; b_rdy <= 1'b1;
		while (b_p) begin
			@(negedge clk);
			aw_h = aw_p && (awrdy === 1'b1);
			w_h = w_p && (wrdy === 1'b1);
			b_h = (bvld === 1'b1);
			if (b_h) resp = bresp;
			@(posedge clk);
			if (aw_h) begin aw_vld <= 1'b0; aw_p = 1'b0; end
			if (w_h) begin w_vld <= 1'b0; w_p = 1'b0; end
			if (b_h) begin b_rdy <= 1'b0; b_p = 1'b0; end
		end
		// One idle edge, so that a following call never drives bready twice in one time step.
		@(posedge clk);
	endtask : axi_write

	task automatic axi_read(input logic [7:0] a);
		logic ar_p, r_p, ar_h, r_h;
		ar_p = 1'b1; r_p = 1'b1;
		ar_addr <= a; ar_vld <= 1'b1; r_rdy <= 1'b1;
		while (r_p) begin
			@(negedge clk);
			ar_h = ar_p && (arrdy === 1'b1);
			r_h = (rvld === 1'b1);
			if (r_h) begin rd = rdata; resp = rresp; end
			@(posedge clk);
			if (ar_h) begin ar_vld <= 1'b0; ar_p = 1'b0; end
			if (r_h) begin r_rdy <= 1'b0; r_p = 1'b0; end
		end
		// One idle edge, so that a following call never drives rready twice in one time step.
		@(posedge clk);
	endtask : axi_read

	// ------------------------------------------------------------------
	// Serial side tasks and model
	// ------------------------------------------------------------------
	// Cycles between two ticks; the first tick after a change is skipped since it may be partial.
	task automatic measure(output int n);
		n = 0;
		do @(negedge clk); while (tick !== 1'b1);
		do begin @(negedge clk); n++; end while (tick !== 1'b1);
		@(posedge clk);
	endtask : measure

	// Counts ticks over a window, toggling the external clock every half cycles when half is nonzero.
	task automatic count_ticks(input int len, input int half, output int n);
		n = 0;
		for (int i = 0; i < len; i++) begin
			@(negedge clk);
			if (tick === 1'b1) n++;
			@(posedge clk);
			if (half != 0 && i % half == 0) ext_clk <= ~ext_clk;
		end
	endtask : count_ticks

	function automatic int model_period(input int sync, input int wide, input int fast, input int hi,
	                                    input int lo);
		int f, n;
		f = sync ? 4 : (!wide && !fast) ? 64 : (wide && fast) ? 4 : 16;
		n = wide ? hi * 256 + lo : lo;
		return f * (n + 1);
	endfunction : model_period

	task automatic wrap_up();
		$display("compared %0d mismatches %0d", n_compared, mismatches);
		if (mismatches == 0 && n_compared > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : wrap_up

	// ------------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------------
	initial begin : main
		int sy, wd, hs, hi, lo;
		void'($urandom(42298));
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		// Reset values, read-only masks and bus refusals.
		axi_read(serial_baud_pkg::ADDR_BAUD);
		`CHK(rd[7:0], serial_baud_pkg::BAUD_RST)
		axi_read(serial_baud_pkg::ADDR_TX_CTRL);
		`CHK(rd[7:0], serial_baud_pkg::TX_CTRL_RST)
		axi_write(serial_baud_pkg::ADDR_BAUD, 32'h000000FF, 4'h1);
		axi_read(serial_baud_pkg::ADDR_BAUD);
		`CHK(rd[7:0], serial_baud_pkg::BAUD_WMSK | serial_baud_pkg::BAUD_RST)
		axi_write(8'h18, 32'h000000FF, 4'h1);
		`CHK(resp, serial_baud_pkg::RESP_SLVERR)
		axi_read(8'h18);
		`CHK(resp, serial_baud_pkg::RESP_SLVERR)
		axi_write(serial_baud_pkg::ADDR_DIV_LO, 32'h00000055, 4'h0);
		axi_read(serial_baud_pkg::ADDR_DIV_LO);
		`CHK(rd, 32'h00000000)
		// Port held off: no ticks at all.
		axi_write(serial_baud_pkg::ADDR_BAUD, 32'h00000000, 4'h1);
		count_ticks(300, 0, k);
		`CHK(k, 0)
		$display("test registers done");
		// Six of the eight mode combinations (sync only with high speed set) with random divisors; high byte set also in narrow modes.
		axi_write(serial_baud_pkg::ADDR_RX_CTRL, 32'h00000080, 4'h1);
		foreach (modes[i]) begin
			sy = modes[i][2]; wd = modes[i][1]; hs = modes[i][0];
			hi = 1 + $urandom % 2; lo = $urandom % 4;
			axi_write(serial_baud_pkg::ADDR_DIV_HI, 32'(hi), 4'h1);
			axi_write(serial_baud_pkg::ADDR_DIV_LO, 32'(lo), 4'h1);
			axi_write(serial_baud_pkg::ADDR_BAUD, 32'(wd << serial_baud_pkg::WIDE_DIV_BIT), 4'h1);
			axi_write(serial_baud_pkg::ADDR_TX_CTRL, 32'((sy << serial_baud_pkg::SYNC_MODE_BIT) |
			          (sy << serial_baud_pkg::CLK_SRC_BIT) | (hs << serial_baud_pkg::HIGH_SPEED_BIT)), 4'h1);
			measure(c);
			measure(c);
			`CHK(c, model_period(sy, wd, hs, hi, lo))
		end
		$display("test modes done");
		// A divisor write restarts the count; the new period holds from the next tick.
		axi_write(serial_baud_pkg::ADDR_TX_CTRL, 32'h00000000, 4'h1);
		axi_write(serial_baud_pkg::ADDR_BAUD, 32'h00000000, 4'h1);
		axi_write(serial_baud_pkg::ADDR_DIV_LO, 32'h00000003, 4'h1);
		measure(c);
		repeat (100) @(posedge clk);
		axi_write(serial_baud_pkg::ADDR_DIV_LO, 32'h00000001, 4'h1);
		@(negedge clk);
		`CHK(tick, 1'b0)
		// The first tick after the restart comes one full new period later, give or take the pipeline.
		c = 0;
		do begin @(negedge clk); c++; end while (tick !== 1'b1);
		`CHK(c >= 120 && c <= 132, 1'b1)
		@(posedge clk);
		measure(c);
		`CHK(c, 128)
		$display("test restart done");
		// Synchronous slave: only external edges make ticks, ten rising edges give ten ticks.
		axi_write(serial_baud_pkg::ADDR_TX_CTRL, 32'(1 << serial_baud_pkg::SYNC_MODE_BIT), 4'h1);
		count_ticks(20, 0, k);
		count_ticks(200, 10, k);
		`CHK(k, 10)
		$display("test slave done");
		// Majority vote: timer ticks every cycle, a one-sample glitch must not pass.
		axi_write(serial_baud_pkg::ADDR_TX_CTRL, 32'h00000090, 4'h1);
		axi_write(serial_baud_pkg::ADDR_DIV_LO, 32'h00000000, 4'h1);
		rx_pin <= 1'b0;
		repeat (20) @(negedge clk);
		`CHK(rx_lvl, 1'b0)
		@(posedge clk);
		axi_read(serial_baud_pkg::ADDR_STATUS);
		`CHK(rd[0], 1'b0)
		rx_pin <= 1'b1;
		@(posedge clk);
		rx_pin <= 1'b0;
		k = 0;
		repeat (12) begin
			@(negedge clk);
			if (rx_lvl !== 1'b0) k++;
		end
		`CHK(k, 0)
		@(posedge clk);
		rx_pin <= 1'b1;
		repeat (20) @(negedge clk);
		`CHK(rx_lvl, 1'b1)
		$display("test vote done");
		wrap_up();
	end : main

endmodule : serial_baud_rate_generator_tb

// ==== inc/serial_baud_pkg.sv ====
// Purpose: Constants and carrier types for the serial bit rate generator.
// Assumes: 32-bit AXI4-Lite register access, one aligned word per register.
// Notes:

package serial_baud_pkg;

	// ------------------------------------------------------------------
	// Register byte addresses
	// ------------------------------------------------------------------
	localparam logic [7:0] ADDR_TX_CTRL = 8'h00;
	localparam logic [7:0] ADDR_RX_CTRL = 8'h04;
	localparam logic [7:0] ADDR_BAUD    = 8'h08;
	localparam logic [7:0] ADDR_DIV_HI  = 8'h0C;
	localparam logic [7:0] ADDR_DIV_LO  = 8'h10;
	localparam logic [7:0] ADDR_STATUS  = 8'h14;

	// ------------------------------------------------------------------
	// Field positions
	// ------------------------------------------------------------------
	localparam int CLK_SRC_BIT    = 7;
	localparam int SYNC_MODE_BIT  = 4;
	localparam int HIGH_SPEED_BIT = 2;
	localparam int PORT_EN_BIT    = 7;
	localparam int WIDE_DIV_BIT   = 3;

	// ------------------------------------------------------------------
	// Reset values and writable masks
	// ------------------------------------------------------------------
	localparam logic [7:0] TX_CTRL_RST  = 8'h02;
	localparam logic [7:0] RX_CTRL_RST  = 8'h00;
	localparam logic [7:0] BAUD_RST     = 8'h40;
	localparam logic [7:0] DIV_RST      = 8'h00;
	localparam logic [7:0] TX_CTRL_WMSK = 8'hFD;
	localparam logic [7:0] RX_CTRL_WMSK = 8'hF8;
	localparam logic [7:0] BAUD_WMSK    = 8'h3B;

	// ------------------------------------------------------------------
	// Prescale factors in timer periods per bit
	// ------------------------------------------------------------------
	localparam logic [6:0] PRESCALE_SLOW = 7'h40;
	localparam logic [6:0] PRESCALE_MID  = 7'h10;
	localparam logic [6:0] PRESCALE_FAST = 7'h04;

	// ------------------------------------------------------------------
	// Bus answers
	// ------------------------------------------------------------------
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// ------------------------------------------------------------------
	// Carrier types
	// ------------------------------------------------------------------
	typedef struct packed {
		logic [7:0] tx_ctrl;
		logic [7:0] rx_ctrl;
		logic [7:0] baud;
		logic [7:0] div_hi;
		logic [7:0] div_lo;
	} ctrl_regs_s;

	typedef struct packed {
		ctrl_regs_s regs;
		logic       awready;
		logic       aw_held;
		logic [7:0] aw_addr;
		logic       wready;
		logic       w_held;
		logic [7:0] w_data;
		logic       w_lane0;
		logic       bvalid;
		logic [1:0] bresp;
		logic       arready;
		logic       rvalid;
		logic [1:0] rresp;
		logic [7:0] rdata;
		logic       restart;
		logic [6:0] presc;
		logic       bit_tick;
		logic [2:0] sck_sync;
		logic [1:0] rx_sync;
		logic [2:0] rx_samples;
		logic       rx_level;
	} core_state_s;

	typedef struct packed {
		logic [15:0] count;
		logic        tick;
	} timer_state_s;

endpackage : serial_baud_pkg

// ==== logic/bit_rate_timer.sv ====
// Purpose: Free-running period timer that paces the serial bit rate.
// Assumes: Period and restart come from logic on the same clock.
// Notes: The tick is registered, one cycle wide, once per period + 1 clocks.

`timescale 1ns/1ps

module bit_rate_timer (
	// Clock and reset
	input  wire logic        clk_in,
	input  wire logic        rst_in,
	// Control
	input  wire logic        restart_in,
	input  wire logic [15:0] period_in,
	// Pacing
	output logic             tick_out
);

	serial_baud_pkg::timer_state_s st_r;
	serial_baud_pkg::timer_state_s st_nxt;

	// ------------------------------------------------------------------
	// Counter
	// ------------------------------------------------------------------

	// A count past a freshly lowered period wraps at once instead of running to 65535.
	always_comb begin
		st_nxt      = st_r;
		st_nxt.tick = 1'b0;
		if (restart_in) begin
			st_nxt.count = 16'h0000;
		end else if (st_r.count >= period_in) begin
			st_nxt.count = 16'h0000;
			st_nxt.tick  = 1'b1;
		end else begin
			st_nxt.count = st_r.count + 16'h0001;
		end
	end

	// State register.
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign tick_out = st_r.tick;

	// ------------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------------
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (rst_in);

	chk_restart_clears: assert property (restart_in |=> st_r.count == 16'h0000 && !st_r.tick)
		else $error("timer not cleared by restart");

	sequence wrap_seen;
		!restart_in && st_r.count == period_in && period_in != 16'h0000;
	endsequence

	chk_tick_period: assert property (wrap_seen |=> tick_out ##1 !tick_out)
		else $error("timer tick not one cycle after period end");

endmodule : bit_rate_timer

// ==== logic/serial_baud_rate_generator.sv ====
// Purpose: Bit rate generator for the enhanced serial port with AXI4-Lite registers.
// Assumes: Single 200 MHz clock; receive pin and external clock are asynchronous.
// Notes: Emits one bit-rate tick per bit period and a majority-voted receive level.
//
// Implementation choices: the register addresses and the AXI4-Lite interface to the registers.

`timescale 1ns/1ps

module serial_baud_rate_generator (
	// Clock and reset
	input  wire logic        CORE_CLK_IN,
	input  wire logic        RST_IN,
	// AXI4-Lite write address
	input  wire logic [7:0]  AXI_AWADDR_IN,
	input  wire logic        AXI_AWVALID_IN,
	output logic             AXI_AWREADY_OUT,
	// AXI4-Lite write data
	input  wire logic [31:0] AXI_WDATA_IN,
	input  wire logic [3:0]  AXI_WSTRB_IN,
	input  wire logic        AXI_WVALID_IN,
	output logic             AXI_WREADY_OUT,
	// AXI4-Lite write response
	output logic [1:0]       AXI_BRESP_OUT,
	output logic             AXI_BVALID_OUT,
	input  wire logic        AXI_BREADY_IN,
	// AXI4-Lite read address
	input  wire logic [7:0]  AXI_ARADDR_IN,
	input  wire logic        AXI_ARVALID_IN,
	output logic             AXI_ARREADY_OUT,
	// AXI4-Lite read data
	output logic [31:0]      AXI_RDATA_OUT,
	output logic [1:0]       AXI_RRESP_OUT,
	output logic             AXI_RVALID_OUT,
	input  wire logic        AXI_RREADY_IN,
	// Serial pins
	input  wire logic        RX_PIN_IN,
	input  wire logic        EXT_CLK_PIN_IN,
	// Serial port side
	output logic             BIT_TICK_OUT,
	output logic             RX_LEVEL_OUT
);

	// ------------------------------------------------------------------
	// Helper functions
	// ------------------------------------------------------------------

	// Timer periods per bit for the selected mode.
	function automatic logic [6:0] prescale_of(input logic sync, input logic wide, input logic fast);
		if (sync) begin
			return serial_baud_pkg::PRESCALE_FAST;
		end else if (!wide && !fast) begin
			return serial_baud_pkg::PRESCALE_SLOW;
		end else if (wide && fast) begin
			return serial_baud_pkg::PRESCALE_FAST;
		end else begin
			return serial_baud_pkg::PRESCALE_MID;
		end
	endfunction : prescale_of

	// Divisor n from the byte pair; the high byte drops out in narrow mode.
	function automatic logic [15:0] divisor_of(input serial_baud_pkg::ctrl_regs_s regs);
		if (regs.baud[serial_baud_pkg::WIDE_DIV_BIT]) begin
			return {regs.div_hi, regs.div_lo};
		end else begin
			return {8'h00, regs.div_lo};
		end
	endfunction : divisor_of

	// Address decode shared by the read and write paths.
	function automatic logic addr_known(input logic [7:0] addr);
		return addr == serial_baud_pkg::ADDR_TX_CTRL || addr == serial_baud_pkg::ADDR_RX_CTRL ||
		       addr == serial_baud_pkg::ADDR_BAUD || addr == serial_baud_pkg::ADDR_DIV_HI ||
		       addr == serial_baud_pkg::ADDR_DIV_LO || addr == serial_baud_pkg::ADDR_STATUS;
	endfunction : addr_known

	// Masked merge so that read-only bits keep their reset value.
	function automatic logic [7:0] merge(input logic [7:0] old, input logic [7:0] wr, input logic [7:0] msk);
		return (old & ~msk) | (wr & msk);
	endfunction : merge

	// ------------------------------------------------------------------
	// State and derived controls
	// ------------------------------------------------------------------
	serial_baud_pkg::core_state_s st_r;
	serial_baud_pkg::core_state_s st_nxt;

	logic        sync_mode;
	logic        clk_master;
	logic        high_speed;
	logic        wide_div;
	logic        port_en;
	logic [15:0] divisor;
	logic [6:0]  prescale;
	logic        timer_tick;
	logic        ext_rise;
	logic        internal_clk;

	// Mode bits seen by the rate logic.
	always_comb begin
		sync_mode    = st_r.regs.tx_ctrl[serial_baud_pkg::SYNC_MODE_BIT];
		clk_master   = st_r.regs.tx_ctrl[serial_baud_pkg::CLK_SRC_BIT];
		high_speed   = st_r.regs.tx_ctrl[serial_baud_pkg::HIGH_SPEED_BIT];
		wide_div     = st_r.regs.baud[serial_baud_pkg::WIDE_DIV_BIT];
		port_en      = st_r.regs.rx_ctrl[serial_baud_pkg::PORT_EN_BIT];
		divisor      = divisor_of(st_r.regs);
		prescale     = prescale_of(sync_mode, wide_div, high_speed);
		internal_clk = !sync_mode || clk_master;
		ext_rise     = st_r.sck_sync[1] && !st_r.sck_sync[2];
	end

	// ------------------------------------------------------------------
	// Period timer
	// ------------------------------------------------------------------

	// Held cleared while the port is off so the first bit after enabling is full length.
	bit_rate_timer u_timer (
		.clk_in     (CORE_CLK_IN),
		.rst_in     (RST_IN),
		.restart_in (st_r.restart || !port_en),
		.period_in  (divisor),
		.tick_out   (timer_tick)
	);

	// ------------------------------------------------------------------
	// Next-state logic
	// ------------------------------------------------------------------

	// Bus slave, rate prescaler, pin synchronisers and the receive vote.
	always_comb begin
		st_nxt          = st_r;
		st_nxt.restart  = 1'b0;
		st_nxt.bit_tick = 1'b0;

		// Write address and data are taken independently, in either order.
		if (AXI_AWVALID_IN && st_r.awready) begin
			st_nxt.awready = 1'b0;
			st_nxt.aw_held = 1'b1;
			st_nxt.aw_addr = AXI_AWADDR_IN;
		end
		if (AXI_WVALID_IN && st_r.wready) begin
			st_nxt.wready  = 1'b0;
			st_nxt.w_held  = 1'b1;
			st_nxt.w_data  = AXI_WDATA_IN[7:0];
			st_nxt.w_lane0 = AXI_WSTRB_IN[0];
		end

		// Both halves present: commit the write and answer.
		if (st_r.aw_held && st_r.w_held && !st_r.bvalid) begin
			st_nxt.aw_held = 1'b0;
			st_nxt.w_held  = 1'b0;
			st_nxt.bvalid  = 1'b1;
			st_nxt.bresp   = addr_known(st_r.aw_addr) ? serial_baud_pkg::RESP_OKAY : serial_baud_pkg::RESP_SLVERR;
			if (st_r.w_lane0) begin
				unique case (st_r.aw_addr)
					serial_baud_pkg::ADDR_TX_CTRL: begin
						st_nxt.regs.tx_ctrl = merge(st_r.regs.tx_ctrl, st_r.w_data, serial_baud_pkg::TX_CTRL_WMSK);
					end
					serial_baud_pkg::ADDR_RX_CTRL: begin
						st_nxt.regs.rx_ctrl = merge(st_r.regs.rx_ctrl, st_r.w_data, serial_baud_pkg::RX_CTRL_WMSK);
					end
					serial_baud_pkg::ADDR_BAUD: begin
						st_nxt.regs.baud = merge(st_r.regs.baud, st_r.w_data, serial_baud_pkg::BAUD_WMSK);
					end
					serial_baud_pkg::ADDR_DIV_HI: begin
						st_nxt.regs.div_hi = st_r.w_data;
						st_nxt.restart     = 1'b1;
					end
					serial_baud_pkg::ADDR_DIV_LO: begin
						st_nxt.regs.div_lo = st_r.w_data;
						st_nxt.restart     = 1'b1;
					end
					default: begin
					end
				endcase
			end
		end
		if (st_r.bvalid && AXI_BREADY_IN) begin
			st_nxt.bvalid  = 1'b0;
			st_nxt.awready = 1'b1;
			st_nxt.wready  = 1'b1;
		end

		// Reads answer one cycle after the address is taken.
		if (AXI_ARVALID_IN && st_r.arready) begin
			st_nxt.arready = 1'b0;
			st_nxt.rvalid  = 1'b1;
			st_nxt.rresp   = addr_known(AXI_ARADDR_IN) ? serial_baud_pkg::RESP_OKAY : serial_baud_pkg::RESP_SLVERR;
			unique case (AXI_ARADDR_IN)
				serial_baud_pkg::ADDR_TX_CTRL: st_nxt.rdata = st_r.regs.tx_ctrl;
				serial_baud_pkg::ADDR_RX_CTRL: st_nxt.rdata = st_r.regs.rx_ctrl;
				serial_baud_pkg::ADDR_BAUD:    st_nxt.rdata = st_r.regs.baud;
				serial_baud_pkg::ADDR_DIV_HI:  st_nxt.rdata = st_r.regs.div_hi;
				serial_baud_pkg::ADDR_DIV_LO:  st_nxt.rdata = st_r.regs.div_lo;
				serial_baud_pkg::ADDR_STATUS:  st_nxt.rdata = {6'h00, st_r.sck_sync[1], st_r.rx_level};
				default:                       st_nxt.rdata = 8'h00;
			endcase
		end
		if (st_r.rvalid && AXI_RREADY_IN) begin
			st_nxt.rvalid  = 1'b0;
			st_nxt.arready = 1'b1;
		end

		// Pin synchronisers; only the second and later stages feed logic.
		st_nxt.sck_sync = {st_r.sck_sync[1:0], EXT_CLK_PIN_IN};
		st_nxt.rx_sync  = {st_r.rx_sync[0], RX_PIN_IN};

		// Prescaler counts timer periods; a divisor write restarts it with the timer.
		if (!port_en || st_nxt.restart) begin
			st_nxt.presc = 7'h00;
		end else if (internal_clk && timer_tick) begin
			if (st_r.presc >= prescale - 7'h01) begin
				st_nxt.presc    = 7'h00;
				st_nxt.bit_tick = 1'b1;
			end else begin
				st_nxt.presc = st_r.presc + 7'h01;
			end
		end
		// Slave timing follows the external clock's rising edge only.
		if (port_en && !internal_clk && ext_rise) begin
			st_nxt.bit_tick = 1'b1;
		end

		// Three samples at the timer rate; two of three decide the level.
		if (timer_tick) begin
			st_nxt.rx_samples = {st_r.rx_samples[1:0], st_r.rx_sync[1]};
			st_nxt.rx_level   = (st_r.rx_samples[1] & st_r.rx_samples[0]) |
			                    (st_r.rx_samples[1] & st_r.rx_sync[1]) |
			                    (st_r.rx_samples[0] & st_r.rx_sync[1]);
		end
	end

	// ------------------------------------------------------------------
	// State register
	// ------------------------------------------------------------------

	// Receive samples reset high so the line reads idle until real samples arrive.
	always_ff @(posedge CORE_CLK_IN) begin
		if (RST_IN) begin
			st_r                 <= '0;
			st_r.regs.tx_ctrl    <= serial_baud_pkg::TX_CTRL_RST;
			st_r.regs.rx_ctrl    <= serial_baud_pkg::RX_CTRL_RST;
			st_r.regs.baud       <= serial_baud_pkg::BAUD_RST;
			st_r.regs.div_hi     <= serial_baud_pkg::DIV_RST;
			st_r.regs.div_lo     <= serial_baud_pkg::DIV_RST;
			st_r.awready         <= 1'b1;
			st_r.wready          <= 1'b1;
			st_r.arready         <= 1'b1;
			st_r.rx_samples      <= 3'h7;
			st_r.rx_level        <= 1'b1;
		end else begin
			st_r <= st_nxt;
		end
	end

	// ------------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------------

	// Every output is a state bit; read data above bit 7 is constant zero.
	assign AXI_AWREADY_OUT = st_r.awready;
	assign AXI_WREADY_OUT  = st_r.wready;
	assign AXI_BVALID_OUT  = st_r.bvalid;
	assign AXI_BRESP_OUT   = st_r.bresp;
	assign AXI_ARREADY_OUT = st_r.arready;
	assign AXI_RVALID_OUT  = st_r.rvalid;
	assign AXI_RRESP_OUT   = st_r.rresp;
	assign AXI_RDATA_OUT   = {24'h000000, st_r.rdata};
	assign BIT_TICK_OUT    = st_r.bit_tick;
	assign RX_LEVEL_OUT    = st_r.rx_level;

	// ------------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------------
	default clocking cb @(posedge CORE_CLK_IN); endclocking
	default disable iff (RST_IN);

	chk_reset_narrow: assert property ($past(RST_IN) |-> !wide_div && divisor[15:8] == 8'h00)
		else $error("divider not narrow after reset");

	chk_high_ignored: assert property (!wide_div |-> divisor == {8'h00, st_r.regs.div_lo})
		else $error("high divisor byte used in narrow mode");

	chk_pair_order: assert property (wide_div |-> divisor[15:8] == st_r.regs.div_hi)
		else $error("divisor pair order wrong");

	chk_async_slow: assert property (!sync_mode && !wide_div && !high_speed |-> prescale == 7'h40)
		else $error("slow async factor not 64");

	chk_async_mid: assert property (!sync_mode && (wide_div ^ high_speed) |-> prescale == 7'h10)
		else $error("mid async factor not 16");

	chk_fast_modes: assert property (sync_mode || (wide_div && high_speed) |-> prescale == 7'h04)
		else $error("sync or fast async factor not 4");

	sequence div_write;
		st_r.bvalid && $rose(st_r.bvalid) && st_r.bresp == 2'h0 &&
		($past(st_r.aw_addr) == serial_baud_pkg::ADDR_DIV_HI || $past(st_r.aw_addr) == serial_baud_pkg::ADDR_DIV_LO) &&
		$past(st_r.w_lane0);
	endsequence

	chk_div_restart: assert property (div_write |-> st_r.restart && st_r.presc == 7'h00 ##1 !BIT_TICK_OUT)
		else $error("divisor write did not restart the rate");

	sequence tick_then_quiet;
		BIT_TICK_OUT ##1 !BIT_TICK_OUT [*3];
	endsequence

	chk_tick_spacing: assert property (internal_clk && BIT_TICK_OUT && port_en |-> tick_then_quiet)
		else $error("internal bit ticks closer than four cycles");

	chk_slave_edge: assert property (!internal_clk && BIT_TICK_OUT |-> $past(ext_rise))
		else $error("slave tick without external clock edge");

	chk_vote_high: assert property (timer_tick && st_r.rx_samples[1:0] == 2'h3 |=> RX_LEVEL_OUT)
		else $error("majority of high samples did not give high");

	chk_vote_low: assert property (timer_tick && st_r.rx_samples[1:0] == 2'h0 |=> !RX_LEVEL_OUT)
		else $error("majority of low samples did not give low");

endmodule : serial_baud_rate_generator
